// File: logic/freg_pkg.sv
package freg_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 50;
  localparam int REGW_TIME_NS = 2000;
  localparam int REGW_CYCLES =
    (REGW_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************
  // register fields
  // ****************************************
  localparam int ST1_WR_DIS = 7;
  localparam int ST1_PERR = 6;
  localparam int ST1_EERR = 5;
  localparam int ST1_BP_HI = 4;
  localparam int ST1_BP_LO = 2;
  localparam int ST1_WR_EN = 1;
  localparam int ST1_BUSY = 0;
  localparam int CFG_LAT_HI = 7;
  localparam int CFG_LAT_LO = 6;
  localparam int CFG_PSS = 5;
  localparam int CFG_PFV = 3;
  localparam int CFG_SSL = 2;
  localparam int CFG_QUAD = 1;
  localparam int CFG_FRZ = 0;
  localparam int ST2_ERS_HOLD = 1;
  localparam int ST2_PH = 0;
  localparam int BANK_FOUR = 7;
  localparam int BANK_HIGH = 1;
  localparam int BANK_LOW = 0;
  localparam logic [7:0] REG_CLEAR = 8'h00;
  localparam logic [7:0] CFG_NV_MASK = 8'hee;
  localparam logic [7:0] CFG_SSL_MASK = 8'h04;
  localparam logic [2:0] BP_NONE = 3'h0;
  localparam logic [2:0] BP_ALL = 3'h7;
  localparam int ADDR3_BITS = 24;

  // ****************************************
  // marking area
  // ****************************************
  localparam logic [8:0] MARK_BASE = 9'h180;
  localparam int MARK_BYTES = 32;
  localparam int MARK_IDX_BITS = 5;
  localparam int MARK_RSV_BYTES = 12;
  localparam logic [7:0] MARK_SIZE = 8'h14;
  localparam logic [7:0] MARK_REV = 8'h01;
  localparam logic [7:0] ID_FILL = 8'hff;

  // ****************************************
  // commands and states
  // ****************************************
  typedef enum logic [2:0] {
    CMD_NONE = 3'h0,
    CMD_WRITE_ENABLE = 3'h1,
    CMD_WRITE_DISABLE = 3'h2,
    CMD_WRITE_REGISTERS = 3'h3,
    CMD_PROGRAM = 3'h4,
    CMD_ERASE = 3'h5,
    CMD_BANK_WRITE = 3'h6,
    CMD_CLEAR_STATUS = 3'h7
  } cmd_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_REG_WRITE = 2'b01,
    ST_ARRAY_LAUNCH = 2'b10,
    ST_ARRAY_WAIT = 2'b11
  } op_state_t;

endpackage : freg_pkg

// File: logic/protect_range.sv
`timescale 1ns/1ps
module protect_range #(
  parameter int ADDR_BITS = 25
) (
  // protection selection
  input wire logic [2:0] block_protect,
  input wire logic from_bottom,
  // address under test
  input wire logic [ADDR_BITS-1:0] addr,
  // result
  output logic hit
);

  // each field step doubles the region; step one is 1/64 of the array
  localparam logic [ADDR_BITS:0] FULL = {1'b1, {ADDR_BITS{1'b0}}};

  wire [2:0] shift = freg_pkg::BP_ALL - block_protect;
  wire [ADDR_BITS:0] wide_addr = {1'b0, addr};
  wire [ADDR_BITS:0] span;

  assign span = (block_protect == freg_pkg::BP_NONE) ? '0 : FULL >> shift;
  assign hit = from_bottom ? (wide_addr < span)
                           : (wide_addr >= FULL - span);

endmodule : protect_range

// File: logic/flash_status_regs.sv
`timescale 1ns/1ps
module flash_status_regs #(
  parameter int ADDR_BITS = 25,
  parameter bit UNIFORM_SECTORS = 1'b0,
  parameter logic [7:0] NV_STATUS_ONE = 8'h00,
  parameter logic [7:0] NV_CONFIG_ONE = 8'h00,
  // marking values are arbitrary, to be set per die
  parameter logic [63:0] FAB_LOT = 64'h41414141414141ff,
  parameter logic [7:0] WAFER_NUMBER = 8'h01,
  parameter logic [7:0] DIE_X = 8'h01,
  parameter logic [7:0] DIE_Y = 8'h01,
  parameter logic [55:0] CLASS_LOT = 56'h42424242424242
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  // write protect pin
  input wire logic wp_n,
  // decoded command from the serial front end
  input wire logic cmd_valid,
  input wire freg_pkg::cmd_t cmd_op,
  input wire logic [7:0] cmd_status_data,
  input wire logic [7:0] cmd_config_data,
  input wire logic cmd_config_present,
  input wire logic [7:0] cmd_bank_data,
  input wire logic [31:0] cmd_addr,
  // array engine
  input wire logic array_busy,
  input wire logic program_fail,
  input wire logic erase_fail,
  input wire logic erase_held,
  input wire logic program_held,
  // identification read
  input wire logic [8:0] id_offset,
  output logic [7:0] id_data,
  // registers
  output logic [7:0] status_one,
  output logic [7:0] configuration_one,
  output logic [7:0] status_two,
  output logic [7:0] bank_address,
  // mode outputs
  output logic [1:0] read_latency_code,
  output logic quad_mode,
  output logic four_byte_mode,
  // array launch
  output logic program_go,
  output logic erase_go,
  output logic [31:0] target_addr,
  output logic cmd_ignored
);

  // ****************************************
  // elaboration checks
  // ****************************************
  if (ADDR_BITS < freg_pkg::ADDR3_BITS || ADDR_BITS > 32) begin : g_bad
    $error("ADDR_BITS must lie between 24 and 32");
  end

  localparam int WCW = $clog2(freg_pkg::REGW_CYCLES + 1);
  localparam logic [WCW-1:0] REGW_LAST = WCW'(freg_pkg::REGW_CYCLES - 1);
  localparam logic [2:0] BP_RESET = NV_CONFIG_ONE[freg_pkg::CFG_PFV] ?
    freg_pkg::BP_ALL : NV_STATUS_ONE[freg_pkg::ST1_BP_HI:freg_pkg::ST1_BP_LO];
  localparam logic [7:0] CFG_KEEP = UNIFORM_SECTORS ?
    (freg_pkg::CFG_NV_MASK & ~freg_pkg::CFG_SSL_MASK) : freg_pkg::CFG_NV_MASK;
  localparam logic [8:0] MARK_END = 9'(freg_pkg::MARK_BASE
    + freg_pkg::MARK_BYTES);
  localparam logic [freg_pkg::MARK_BYTES*8-1:0] MARK_IMAGE = {
    freg_pkg::MARK_SIZE, freg_pkg::MARK_REV, FAB_LOT, WAFER_NUMBER,
    DIE_X, DIE_Y, CLASS_LOT,
    {freg_pkg::MARK_RSV_BYTES{freg_pkg::ID_FILL}}};

  // ****************************************
  // pin synchroniser
  // ****************************************
  logic wp_meta;
  logic wp_sync;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wp_meta <= 1'b1;
      wp_sync <= 1'b1;
    end else if (ce) begin
      wp_meta <= wp_n;
      wp_sync <= wp_meta;
    end
  end

  // ****************************************
  // field views and command decode
  // ****************************************
  freg_pkg::op_state_t state;
  freg_pkg::op_state_t next_state;
  logic [WCW-1:0] regw_count;
  logic range_hit;
  logic [31:0] eff_addr;

  wire wr_dis = status_one[freg_pkg::ST1_WR_DIS];
  wire wr_en = status_one[freg_pkg::ST1_WR_EN];
  wire busy = status_one[freg_pkg::ST1_BUSY];
  wire freeze = configuration_one[freg_pkg::CFG_FRZ];
  wire [2:0] bp = status_one[freg_pkg::ST1_BP_HI:freg_pkg::ST1_BP_LO];
  wire from_bottom = configuration_one[freg_pkg::CFG_PSS];
  wire pin_lock = wr_dis & ~wp_sync;

  // nothing but reads is taken while busy
  wire take = ce & cmd_valid & ~busy;
  wire is_wr_en = take & (cmd_op == freg_pkg::CMD_WRITE_ENABLE);
  wire is_wr_dis = take & (cmd_op == freg_pkg::CMD_WRITE_DISABLE);
  wire is_regw = take & (cmd_op == freg_pkg::CMD_WRITE_REGISTERS);
  wire is_prog = take & (cmd_op == freg_pkg::CMD_PROGRAM);
  wire is_erase = take & (cmd_op == freg_pkg::CMD_ERASE);
  wire is_bank = take & (cmd_op == freg_pkg::CMD_BANK_WRITE);
  wire is_clear = take & (cmd_op == freg_pkg::CMD_CLEAR_STATUS);
  wire regw_ok = is_regw & wr_en & ~pin_lock;
  wire prog_ok = is_prog & wr_en & ~range_hit;
  wire erase_ok = is_erase & wr_en & ~range_hit;
  wire cfg_wr = regw_ok & cmd_config_present;
  wire any_ok = is_wr_en | is_wr_dis | regw_ok | prog_ok | erase_ok
              | is_bank | is_clear;
  wire refused = ce & cmd_valid & (cmd_op != freg_pkg::CMD_NONE) & ~any_ok;
  wire four_byte = bank_address[freg_pkg::BANK_FOUR];
  wire in_mark = (id_offset >= freg_pkg::MARK_BASE) & (id_offset < MARK_END);
  wire [8:0] mark_rel = id_offset - freg_pkg::MARK_BASE;
  wire [freg_pkg::MARK_IDX_BITS-1:0] mark_idx =
    mark_rel[freg_pkg::MARK_IDX_BITS-1:0];

  // ****************************************
  // address extension and protection
  // ****************************************
  always_comb begin
    eff_addr = cmd_addr;
    if (!four_byte) begin
      eff_addr[31:freg_pkg::ADDR3_BITS] = '0;
      eff_addr[freg_pkg::ADDR3_BITS +: 2] =
        bank_address[freg_pkg::BANK_HIGH:freg_pkg::BANK_LOW];
    end
  end

  protect_range #(
    .ADDR_BITS(ADDR_BITS)
  ) u_range (
    .block_protect(bp),
    .from_bottom(from_bottom),
    .addr(eff_addr[ADDR_BITS-1:0]),
    .hit(range_hit)
  );

  // ****************************************
  // next register values
  // ****************************************
  logic [7:0] next_status;
  logic [7:0] next_config;
  logic [7:0] next_bank;

  always_comb begin
    next_status = status_one;
    if (regw_ok) begin
      next_status[freg_pkg::ST1_WR_DIS] =
        cmd_status_data[freg_pkg::ST1_WR_DIS];
      if (!freeze) begin
        next_status[freg_pkg::ST1_BP_HI:freg_pkg::ST1_BP_LO] =
          cmd_status_data[freg_pkg::ST1_BP_HI:freg_pkg::ST1_BP_LO];
      end
    end
    if (is_wr_en) begin
      next_status[freg_pkg::ST1_WR_EN] = 1'b1;
    end else if (is_wr_dis) begin
      next_status[freg_pkg::ST1_WR_EN] = 1'b0;
    end
    // a failure in the clearing cycle still leaves the flag set
    next_status[freg_pkg::ST1_PERR] = program_fail
      | (status_one[freg_pkg::ST1_PERR] & ~is_clear);
    next_status[freg_pkg::ST1_EERR] = erase_fail
      | (status_one[freg_pkg::ST1_EERR] & ~is_clear);
    next_status[freg_pkg::ST1_BUSY] =
      (next_state != freg_pkg::ST_IDLE) | array_busy;
  end

  always_comb begin
    next_config = configuration_one;
    if (cfg_wr) begin
      next_config[freg_pkg::CFG_LAT_HI:freg_pkg::CFG_LAT_LO] =
        cmd_config_data[freg_pkg::CFG_LAT_HI:freg_pkg::CFG_LAT_LO];
      next_config[freg_pkg::CFG_QUAD] =
        cmd_config_data[freg_pkg::CFG_QUAD];
      // one-time bits only ever go from zero to one
      next_config[freg_pkg::CFG_PFV] = configuration_one[freg_pkg::CFG_PFV]
        | cmd_config_data[freg_pkg::CFG_PFV];
      next_config[freg_pkg::CFG_FRZ] = configuration_one[freg_pkg::CFG_FRZ]
        | cmd_config_data[freg_pkg::CFG_FRZ];
      if (!freeze) begin
        next_config[freg_pkg::CFG_PSS] = configuration_one[freg_pkg::CFG_PSS]
          | cmd_config_data[freg_pkg::CFG_PSS];
        next_config[freg_pkg::CFG_SSL] = configuration_one[freg_pkg::CFG_SSL]
          | cmd_config_data[freg_pkg::CFG_SSL];
      end
    end
    next_config = next_config
      & (CFG_KEEP | (8'h01 << freg_pkg::CFG_FRZ));
  end

  always_comb begin
    next_bank = bank_address;
    if (is_bank) begin
      next_bank = freg_pkg::REG_CLEAR;
      next_bank[freg_pkg::BANK_FOUR] = cmd_bank_data[freg_pkg::BANK_FOUR];
      // bank bits beyond the array stay reserved and read zero
      if (ADDR_BITS > freg_pkg::ADDR3_BITS) begin
        next_bank[freg_pkg::BANK_LOW] =
          cmd_bank_data[freg_pkg::BANK_LOW];
      end
      if (ADDR_BITS > freg_pkg::ADDR3_BITS + 1) begin
        next_bank[freg_pkg::BANK_HIGH] = cmd_bank_data[freg_pkg::BANK_HIGH];
      end
    end
  end

  // ****************************************
  // operation sequencer
  // ****************************************
  always_comb begin
    next_state = state;
    case (state)
      freg_pkg::ST_IDLE: begin
        if (regw_ok) begin
          next_state = freg_pkg::ST_REG_WRITE;
        end else if (prog_ok || erase_ok) begin
          next_state = freg_pkg::ST_ARRAY_LAUNCH;
        end
      end
      freg_pkg::ST_REG_WRITE: begin
        if (regw_count == REGW_LAST) begin
          next_state = freg_pkg::ST_IDLE;
        end
      end
      freg_pkg::ST_ARRAY_LAUNCH: begin
        next_state = freg_pkg::ST_ARRAY_WAIT;
      end
      freg_pkg::ST_ARRAY_WAIT: begin
        if (!array_busy) begin
          next_state = freg_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = freg_pkg::ST_IDLE;
      end
    endcase
  end

  // ****************************************
  // marking read-out
  // ****************************************
  logic [7:0] mark_byte [freg_pkg::MARK_BYTES];

  for (genvar i = 0; i < freg_pkg::MARK_BYTES; i++) begin : g_mark
    assign mark_byte[i] =
      MARK_IMAGE[(freg_pkg::MARK_BYTES - 1 - i) * 8 +: 8];
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= freg_pkg::ST_IDLE;
      regw_count <= '0;
    end else if (ce) begin
      state <= next_state;
      regw_count <= (state == freg_pkg::ST_REG_WRITE) ?
        regw_count + 1'b1 : '0;
    end
  end

  // nonvolatile bits come back from the parameter image at every reset
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      status_one <= freg_pkg::REG_CLEAR;
      status_one[freg_pkg::ST1_WR_DIS] <= NV_STATUS_ONE[freg_pkg::ST1_WR_DIS];
      status_one[freg_pkg::ST1_BP_HI:freg_pkg::ST1_BP_LO] <= BP_RESET;
      configuration_one <= NV_CONFIG_ONE & CFG_KEEP;
      bank_address <= freg_pkg::REG_CLEAR;
      status_two <= freg_pkg::REG_CLEAR;
    end else if (ce) begin
      status_one <= next_status;
      configuration_one <= next_config;
      bank_address <= next_bank;
      status_two[freg_pkg::ST2_ERS_HOLD] <= erase_held;
      status_two[freg_pkg::ST2_PH] <= program_held;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      program_go <= 1'b0;
      erase_go <= 1'b0;
      target_addr <= '0;
      cmd_ignored <= 1'b0;
      id_data <= freg_pkg::ID_FILL;
    end else if (ce) begin
      program_go <= prog_ok;
      erase_go <= erase_ok;
      target_addr <= (prog_ok || erase_ok) ? eff_addr : target_addr;
      cmd_ignored <= refused;
      id_data <= in_mark ? mark_byte[mark_idx] : freg_pkg::ID_FILL;
    end
  end

  assign read_latency_code =
    configuration_one[freg_pkg::CFG_LAT_HI:freg_pkg::CFG_LAT_LO];
  assign quad_mode = configuration_one[freg_pkg::CFG_QUAD];
  assign four_byte_mode = four_byte;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  chk_pin_lock: assert property (
    (ce && cmd_valid && cmd_op == freg_pkg::CMD_WRITE_REGISTERS
     && wr_dis && !wp_sync) |=> $stable(bp) && $stable(configuration_one))
    else $error("register write taken while pin lock active");
  chk_error_flag: assert property (
    (ce && program_fail) |=> status_one[freg_pkg::ST1_PERR])
    else $error("program error flag not set");
  chk_range_block: assert property (
    (ce && cmd_valid && cmd_op == freg_pkg::CMD_PROGRAM && range_hit)
    |=> !program_go)
    else $error("program launched into protected range");
  chk_go_needs_latch: assert property (
    $rose(program_go) || $rose(erase_go) |-> $past(wr_en))
    else $error("array launch without write enable latch");
  chk_latch_source: assert property (
    (ce && !is_wr_en && !is_wr_dis) |=> $stable(wr_en))
    else $error("write enable latch changed by other command");
  chk_regw_busy: assert property (
    regw_ok |=> busy [*8] ##0 (state == freg_pkg::ST_REG_WRITE))
    else $error("busy dropped during register write");
  chk_idle_ready: assert property (
    (ce && state == freg_pkg::ST_IDLE && !array_busy && !any_ok) |=> !busy)
    else $error("busy shown while idle");
  chk_freeze_hold: assert property (
    (ce && freeze) |=> $stable(bp) && $stable(from_bottom))
    else $error("protection changed while frozen");
  chk_suspend_view: assert property (
    ce |=> status_two[freg_pkg::ST2_ERS_HOLD] == $past(erase_held)
       && status_two[freg_pkg::ST2_PH] == $past(program_held))
    else $error("suspend flags do not follow engine");
  chk_wide_addr: assert property (
    (prog_ok && four_byte) |=> target_addr == $past(cmd_addr))
    else $error("four byte address altered");
  chk_bank_bit: assert property (
    (prog_ok && !four_byte) |=> target_addr[freg_pkg::ADDR3_BITS]
      == $past(bank_address[freg_pkg::BANK_LOW]))
    else $error("bank bit not used as address bit");
  chk_mark_size: assert property (
    (ce && id_offset == freg_pkg::MARK_BASE) |=> id_data == freg_pkg::MARK_SIZE)
    else $error("marking size byte wrong");

  cov_reg_write: cover property (regw_ok ##1 busy);
  cov_program: cover property (prog_ok ##1 program_go ##[1:20] !busy);
  cov_pin_lock: cover property (is_regw && wr_en && pin_lock);
  cov_erase: cover property (erase_ok ##1 erase_go);

endmodule : flash_status_regs

// File: tb/array_engine_model.sv
`timescale 1ns/1ps
// **********
// array engine stand-in: busy soon after a launch, optional fail pulse
// **********
module array_engine_model #(
  parameter int BUSY_CYCLES = 6
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // launch from the register block
  input wire logic program_go,
  input wire logic erase_go,
  input wire logic fail_next,
  // status back
  output logic array_busy,
  output logic program_fail,
  output logic erase_fail
);
  int count;
  logic was_program;
  // busy rises on the edge right after go, the latest the block allows
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      count <= 0;
      was_program <= 1'b0;
      array_busy <= 1'b0;
      program_fail <= 1'b0;
      erase_fail <= 1'b0;
    end else begin
      program_fail <= 1'b0;
      erase_fail <= 1'b0;
      if (program_go || erase_go) begin
        array_busy <= 1'b1;
        count <= BUSY_CYCLES;
        was_program <= program_go;
      end else if (count > 1) begin
        count <= count - 1;
      end else if (array_busy) begin
        array_busy <= 1'b0;
        count <= 0;
        program_fail <= fail_next & was_program;
        erase_fail <= fail_next & ~was_program;
      end
    end
  end
endmodule : array_engine_model

// File: tb/serial_flash_status_config_regs_tb.sv
`timescale 1ns/1ps
module serial_flash_status_config_regs_tb;
  // marking values are arbitrary
  localparam logic [63:0] LOT = 64'h5051525354555657;
  localparam logic [55:0] CLS = 56'h60616263646566;
  logic clk = 1'b0, sys_rst = 1'b1, ce = 1'b1, wp_n = 1'b1;
  logic cmd_valid = 1'b0, cfg_p = 1'b0, fail_next = 1'b0;
  freg_pkg::cmd_t cmd_op = freg_pkg::CMD_NONE;
  logic [7:0] sd = 8'h00, cd = 8'h00;
  logic [31:0] addr = 32'h0;
  logic [8:0] id_offset = 9'h000;
  logic array_busy, program_fail, erase_fail, e_held = 0, p_held = 0;
  logic [7:0] id_data, status_one, configuration_one, status_two;
  logic [7:0] bank_address;
  logic [1:0] read_latency_code;
  logic quad_mode, four_byte_mode, program_go, erase_go, cmd_ignored;
  logic [31:0] target_addr;
  int err_total = 0, n_checks = 0;
  always #25 clk = ~clk;
  flash_status_regs #(.FAB_LOT(LOT), .WAFER_NUMBER(8'h11),
    .DIE_X(8'h22), .DIE_Y(8'h33), .CLASS_LOT(CLS)) flash_status_regs_inst (
    .clk(clk), .sys_rst(sys_rst), .ce(ce), .wp_n(wp_n),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_status_data(sd),
    .cmd_config_data(cd), .cmd_config_present(cfg_p),
    .cmd_bank_data(sd), .cmd_addr(addr), .array_busy(array_busy),
    .program_fail(program_fail), .erase_fail(erase_fail),
    .erase_held(e_held), .program_held(p_held), .id_offset(id_offset),
    .id_data(id_data), .status_one(status_one),
    .configuration_one(configuration_one), .status_two(status_two),
    .bank_address(bank_address), .read_latency_code(read_latency_code),
    .quad_mode(quad_mode), .four_byte_mode(four_byte_mode),
    .program_go(program_go), .erase_go(erase_go),
    .target_addr(target_addr), .cmd_ignored(cmd_ignored));
  array_engine_model array_engine_model_inst (
    .clk(clk), .sys_rst(sys_rst), .program_go(program_go),
    .erase_go(erase_go), .fail_next(fail_next), .array_busy(array_busy),
    .program_fail(program_fail), .erase_fail(erase_fail));
  // **********
  // shared tasks
  // **********
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // outputs are looked at in the answer cycle, one edge after taking
  task automatic cmd(freg_pkg::cmd_t op, logic [7:0] s, logic [7:0] c,
    logic p, logic [31:0] a);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_op = op;
    sd = s;
    cd = c;
    cfg_p = p;
    addr = a;
    @(negedge clk);
    cmd_valid = 1'b0;
    cmd_op = freg_pkg::CMD_NONE;
  endtask : cmd
  task automatic wait_idle();
    int n;
    n = 0;
    while (status_one[0] !== 1'b0 && n < 200) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    check("busy_idle", status_one[0], 1'b0);
  endtask : wait_idle
  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  // **********
  // scenarios
  // **********
  task automatic t_reset();
    check("st1_rst", status_one, 8'h00);
    check("cfg_rst", configuration_one, 8'h00);
    check("st2_rst", status_two, 8'h00);
    check("bank_rst", bank_address, 8'h00);
  endtask : t_reset
  task automatic t_latch();
    cmd(freg_pkg::CMD_WRITE_REGISTERS, 8'h1c, 8'h00, 1'b1, 0);
    check("wr_no_en_ign", cmd_ignored, 1'b1);
    check("wr_no_en_st", status_one, 8'h00);
    cmd(freg_pkg::CMD_WRITE_ENABLE, 0, 0, 0, 0);
    check("latch_set", status_one, 8'h02);
    cmd(freg_pkg::CMD_WRITE_DISABLE, 0, 0, 0, 0);
    check("latch_clr", status_one, 8'h00);
    cmd(freg_pkg::CMD_WRITE_ENABLE, 0, 0, 0, 0);
  endtask : t_latch
  task automatic t_write_regs();
    cmd(freg_pkg::CMD_WRITE_REGISTERS, 8'h9c, 8'h42, 1'b1, 0);
    check("wr_st1", status_one, 8'h9f);
    check("wr_cfg", configuration_one, 8'h42);
    check("latency", read_latency_code, 2'h1);
    check("quad", quad_mode, 1'b1);
    repeat (39) @(negedge clk);
    check("busy_hold", status_one[0], 1'b1);
    @(negedge clk);
    check("busy_end", status_one[0], 1'b0);
  endtask : t_write_regs
  task automatic t_protect();
    cmd(freg_pkg::CMD_PROGRAM, 0, 0, 0, 32'h10);
    check("bp_ign", cmd_ignored, 1'b1);
    check("bp_go", program_go, 1'b0);
    wp_n = 1'b0;
    repeat (3) @(negedge clk);
    cmd(freg_pkg::CMD_WRITE_REGISTERS, 8'h00, 8'h42, 1'b1, 0);
    check("pin_lock_ign", cmd_ignored, 1'b1);
    check("pin_lock_st1", status_one, 8'h9e);
    wp_n = 1'b1;
    repeat (3) @(negedge clk);
    cmd(freg_pkg::CMD_WRITE_REGISTERS, 8'h00, 8'h42, 1'b1, 0);
    check("wp_hi_st1", status_one, 8'h03);
    wait_idle();
  endtask : t_protect
  task automatic t_array();
    cmd(freg_pkg::CMD_PROGRAM, 0, 0, 0, 32'h100);
    check("pgm_go", program_go, 1'b1);
    check("pgm_addr", target_addr, 32'h100);
    check("pgm_busy", status_one[0], 1'b1);
    wait_idle();
    check("pgm_ok", status_one, 8'h02);
    fail_next = 1'b1;
    cmd(freg_pkg::CMD_ERASE, 0, 0, 0, 32'h2000);
    check("ers_go", erase_go, 1'b1);
    wait_idle();
    check("ers_err", status_one, 8'h22);
    cmd(freg_pkg::CMD_CLEAR_STATUS, 0, 0, 0, 0);
    check("clr_e", status_one, 8'h02);
    cmd(freg_pkg::CMD_PROGRAM, 0, 0, 0, 32'h300);
    wait_idle();
    check("pgm_err", status_one, 8'h42);
    fail_next = 1'b0;
    cmd(freg_pkg::CMD_CLEAR_STATUS, 0, 0, 0, 0);
    check("clr_p", status_one, 8'h02);
  endtask : t_array
  task automatic t_suspend();
    e_held = 1'b1;
    repeat (2) @(negedge clk);
    check("ers_susp", status_two, 8'h02);
    e_held = 1'b0;
    p_held = 1'b1;
    repeat (2) @(negedge clk);
    check("pgm_susp", status_two, 8'h01);
    p_held = 1'b0;
    repeat (2) @(negedge clk);
    check("no_susp", status_two, 8'h00);
  endtask : t_suspend
  task automatic t_bank();
    cmd(freg_pkg::CMD_BANK_WRITE, 8'h7d, 0, 0, 0);
    check("bank_rsv", bank_address, 8'h01);
    check("three_byte", four_byte_mode, 1'b0);
    cmd(freg_pkg::CMD_PROGRAM, 0, 0, 0, 32'hab123456);
    check("bank_ext", target_addr, 32'h01123456);
    wait_idle();
    cmd(freg_pkg::CMD_BANK_WRITE, 8'h80, 0, 0, 0);
    check("four_byte", four_byte_mode, 1'b1);
    cmd(freg_pkg::CMD_PROGRAM, 0, 0, 0, 32'h01fedcba);
    check("addr32", target_addr, 32'h01fedcba);
    wait_idle();
  endtask : t_bank
  task automatic t_marking();
    logic [7:0] exp;
    for (int i = -1; i < 32; i++) begin
      if (i == 0) exp = 8'h14;
      else if (i == 1) exp = 8'h01;
      else if (i >= 2 && i <= 9) exp = LOT[8*(9-i) +: 8];
      else if (i == 10) exp = 8'h11;
      else if (i == 11) exp = 8'h22;
      else if (i == 12) exp = 8'h33;
      else if (i >= 13 && i <= 19) exp = CLS[8*(19-i) +: 8];
      else exp = 8'hff;
      @(negedge clk);
      id_offset = 9'(384 + i);
      @(negedge clk);
      check("mark_byte", id_data, exp);
    end
  endtask : t_marking
  task automatic t_freeze();
    // bottom start with the smallest field step: lowest 1/64 protected
    cmd(freg_pkg::CMD_WRITE_REGISTERS, 8'h04, 8'h62, 1'b1, 0);
    check("start_sel", configuration_one, 8'h62);
    wait_idle();
    cmd(freg_pkg::CMD_PROGRAM, 0, 0, 0, 32'h0);
    check("bottom_ign", cmd_ignored, 1'b1);
    cmd(freg_pkg::CMD_PROGRAM, 0, 0, 0, 32'h01ffff00);
    check("top_go", program_go, 1'b1);
    wait_idle();
    cmd(freg_pkg::CMD_WRITE_REGISTERS, 8'h00, 8'h43, 1'b1, 0);
    check("frz_set", configuration_one[0], 1'b1);
    wait_idle();
    cmd(freg_pkg::CMD_WRITE_REGISTERS, 8'h1c, 8'h43, 1'b1, 0);
    check("frz_bp", status_one[4:2], 3'h0);
    wait_idle();
  endtask : t_freeze
  initial begin
    // the whole sequence needs well under 2000 cycles
    #(20000 * 50);
    err_total++;
    final_report();
  end
  initial begin
    repeat (10) @(negedge clk);
    sys_rst = 1'b0;
    t_reset();
    t_latch();
    t_write_regs();
    t_protect();
    t_array();
    t_suspend();
    t_bank();
    t_marking();
    t_freeze();
    final_report();
  end
endmodule : serial_flash_status_config_regs_tb
